// File: src/jarp_clamp.sv
`timescale 1ns/1ps
// saturates a signed raw count into [0, max] of an unsigned field
module jarp_clamp
  import jarp_pkg::*;
#(
  parameter int IN_W = 26,
  parameter int OUT_W = 16
) (
  // raw input
  input wire logic signed [IN_W-1:0] raw,
  input wire logic [OUT_W-1:0] max_val,
  // saturated output
  output logic [OUT_W-1:0] packed_val,
  output logic clipped
);
  // ----------------------------------------
  // range check
  // ----------------------------------------
  wire logic below = raw < 0;
  wire logic signed [IN_W:0] max_ext = {{(IN_W + 1 - OUT_W){1'b0}}, max_val};
  wire logic above = {raw[IN_W-1], raw} > max_ext;
  // [R15] clamp to limits
  assign packed_val = below ? '0 : (above ? max_val : raw[OUT_W-1:0]);
  assign clipped = below | above;
endmodule : jarp_clamp

// File: src/jarp_packer.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// [R1] extended slope message, group 61481, every 10 ms when enabled, priority 3
// [R2] extended angles 3 bytes, 1/32768 deg per bit, -250 deg offset
// [R3] roll compensation code: 00 on, 01 off, 10 error, 11 not available
// [R4] slope latency byte 8, 0.5 ms per bit, 0 to 125 ms
// [R5] angular rate message, group 61482, every 10 ms when enabled, priority 3
// [R6] rates bytes 1-6, 1/128 deg/s per bit, -250 deg/s offset
// [R7] rate quality fields at byte 7 bits 1, 3, 5
// [R8] quality code: 00 ok, 01 degraded, 10 error, 11 not available
// [R9] rate latency byte 8, 0.5 ms per bit, zero offset
// [R10] direction message, group 65256, only on request, priority 6
// [R11] direction message unused bearing, speed, altitude all ones
// [R12] direction bytes 5-6 pitch, 1/128 deg per bit, -200 deg offset
// [R13] second direction message, group 64905, on request, roll bytes 1-2
// [R14] multi-byte fields low byte first; unused bytes all ones
// [R15] out of range values clamped to field limits
module jarp_packer
  import jarp_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ,
  // measurements, signed angle and rate counts and unsigned latency counts, already in field resolution, offset removed
  input wire logic signed [25:0] PITCH_EXT,
  input wire logic signed [25:0] ROLL_EXT,
  input wire logic signed [17:0] PITCH_RATE,
  input wire logic signed [17:0] ROLL_RATE,
  input wire logic signed [17:0] YAW_RATE,
  input wire logic signed [17:0] PITCH_DIR,
  input wire logic signed [17:0] ROLL_DIR,
  input wire logic [8:0] ANGLE_LATENCY,
  input wire logic [8:0] RATE_LATENCY,
  // status codes
  input wire logic [1:0] PITCH_COMP,
  input wire logic [1:0] PITCH_MERIT,
  input wire logic [1:0] ROLL_COMP,
  input wire logic [1:0] ROLL_MERIT,
  input wire logic [1:0] PITCH_RATE_MERIT,
  input wire logic [1:0] ROLL_RATE_MERIT,
  input wire logic [1:0] YAW_RATE_MERIT,
  // requests from the network
  input wire logic REQ_DIR,
  input wire logic REQ_DIR_TWO,
  // frame output
  output logic FRAME_VALID,
  input wire logic FRAME_READY,
  output logic [17:0] FRAME_PGN,
  output logic [2:0] FRAME_PRIO,
  output logic [63:0] FRAME_DATA
);
  // ----------------------------------------
  // offsets, pedantic bias into unsigned field
  // ----------------------------------------
  localparam logic signed [25:0] EXT_BIAS = 26'sh07d0000;  // 250 deg * 32768
  localparam logic signed [17:0] RATE_BIAS = 18'sh07d00;   // 250 deg/s * 128
  localparam logic signed [17:0] DIR_BIAS = 18'sh06400;    // 200 deg * 128

  jarp_state_type state_reg;
  jarp_state_type state_next;
  logic [1:0] sel_reg;
  logic [3:0] pend_reg;
  logic [3:0] pend_next;
  logic [31:0] ctrl_reg;
  logic [NUM_EV-1:0] status_reg;
  logic [NUM_EV-1:0] mask_reg;
  logic [15:0] sent_reg;
  logic [NUM_EV-1:0] ev;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic valid_reg;
  logic [17:0] pgn_reg;
  logic [2:0] prio_reg;
  logic [63:0] data_reg;
  logic [63:0] data_next;
  logic [17:0] pgn_next;
  logic [2:0] prio_next;
  logic tick;

  // ----------------------------------------
  // period timer
  // ----------------------------------------
  jarp_timer #(.CYCLES(PERIOD)) u_timer (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .tick(tick)
  );

  // ----------------------------------------
  // scaling and clamping
  // ----------------------------------------
  logic [23:0] pitch_ext_f;
  logic [23:0] roll_ext_f;
  logic [15:0] rate_f [3];
  logic [15:0] pdir_f;
  logic [15:0] rdir_f;
  logic [7:0] alat_f;
  logic [7:0] rlat_f;
  logic [8:0] clip;
  wire logic [2:0][17:0] rate_in = {YAW_RATE, ROLL_RATE, PITCH_RATE};

  // [R2] extended angle offset, one extra bit so a large input cannot wrap past the bias
  jarp_clamp #(.IN_W(27), .OUT_W(24)) u_cp (.raw(27'(PITCH_EXT) + 27'(EXT_BIAS)), .max_val(EXT_ANGLE_MAX),
    .packed_val(pitch_ext_f), .clipped(clip[0]));
  jarp_clamp #(.IN_W(27), .OUT_W(24)) u_cr (.raw(27'(ROLL_EXT) + 27'(EXT_BIAS)), .max_val(EXT_ANGLE_MAX),
    .packed_val(roll_ext_f), .clipped(clip[1]));
  // [R6] rate offset
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_rate
      jarp_clamp #(.IN_W(19), .OUT_W(16)) u_rt (.raw(19'($signed(rate_in[gi])) + 19'(RATE_BIAS)),
        .max_val(WORD_FIELD_MAX), .packed_val(rate_f[gi]), .clipped(clip[2+gi]));
    end
  endgenerate
  // [R12] direction pitch offset
  jarp_clamp #(.IN_W(19), .OUT_W(16)) u_pd (.raw(19'(PITCH_DIR) + 19'(DIR_BIAS)), .max_val(WORD_FIELD_MAX),
    .packed_val(pdir_f), .clipped(clip[5]));
  // [R13] direction roll offset
  jarp_clamp #(.IN_W(19), .OUT_W(16)) u_rd (.raw(19'(ROLL_DIR) + 19'(DIR_BIAS)), .max_val(WORD_FIELD_MAX),
    .packed_val(rdir_f), .clipped(clip[6]));
  // [R4] latency limit
  jarp_clamp #(.IN_W(10), .OUT_W(8)) u_al (.raw({1'b0, ANGLE_LATENCY}), .max_val(LATENCY_MAX),
    .packed_val(alat_f), .clipped(clip[7]));
  // [R9] latency limit
  jarp_clamp #(.IN_W(10), .OUT_W(8)) u_rl (.raw({1'b0, RATE_LATENCY}), .max_val(LATENCY_MAX),
    .packed_val(rlat_f), .clipped(clip[8]));

  // ----------------------------------------
  // payload images, byte 1 in bits 7:0
  // ----------------------------------------
  // [R14] low byte first
  // [R3] compensation codes passed as coded
  wire logic [63:0] img_slope = {alat_f, ROLL_MERIT, ROLL_COMP, PITCH_MERIT, PITCH_COMP,
    roll_ext_f, pitch_ext_f};
  // [R7] quality at 7.1 7.3 7.5
  // [R8] codes passed as coded
  wire logic [63:0] img_rate = {rlat_f, STAT_NA, YAW_RATE_MERIT, ROLL_RATE_MERIT, PITCH_RATE_MERIT,
    rate_f[2], rate_f[1], rate_f[0]};
  // [R11] unused fields all ones
  wire logic [63:0] img_dir = {FILL_WORD, pdir_f, FILL_WORD, FILL_WORD};
  // [R14] unused bytes all ones
  wire logic [63:0] img_dir_two = {{6{FILL_BYTE}}, rdir_f};

  // ----------------------------------------
  // pending requests, lowest index wins
  // ----------------------------------------
  wire logic frame_done = valid_reg & FRAME_READY;
  // [R1] [R5] timed frames on each period tick when enabled
  wire logic [3:0] pend_set = {REQ_DIR_TWO, REQ_DIR, tick & ctrl_reg[CTRL_RATE_EN], tick & ctrl_reg[CTRL_SLOPE_EN]};
  wire logic [1:0] pick = pend_reg[0] ? 2'd0 : (pend_reg[1] ? 2'd1 : (pend_reg[2] ? 2'd2 : 2'd3));
  wire logic load = (state_reg == JARP_IDLE) & (|pend_reg);
  wire logic [3:0] pick_hot = 4'b0001 << pick;

  // new request wins over the clear of the one just taken
  assign pend_next = (pend_reg & ~(load ? pick_hot : 4'b0000)) | pend_set;

  // state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      JARP_IDLE: begin
        if (|pend_reg) begin
          state_next = JARP_LOAD;
        end
      end
      JARP_LOAD: begin
        state_next = JARP_SEND;
      end
      JARP_SEND: begin
        if (frame_done) begin
          state_next = JARP_IDLE;
        end
      end
      default: begin
        state_next = JARP_IDLE;
      end
    endcase
  end

  // frame selection
  always_comb begin
    case (sel_reg)
      // [R1] slope group
      2'd0: begin
        pgn_next = PGN_EXT_SLOPE;
        prio_next = PRIO_PERIODIC;
        data_next = img_slope;
      end
      // [R5] rate group
      2'd1: begin
        pgn_next = PGN_ANG_RATE;
        prio_next = PRIO_PERIODIC;
        data_next = img_rate;
      end
      // [R10] direction on request
      2'd2: begin
        pgn_next = PGN_VEH_DIR;
        prio_next = PRIO_REQUEST;
        data_next = img_dir;
      end
      // [R13] second direction on request
      default: begin
        pgn_next = PGN_VEH_DIR_TWO;
        prio_next = PRIO_REQUEST;
        data_next = img_dir_two;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_reg <= JARP_IDLE;
      pend_reg <= 4'h0;
      sel_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      if (load) begin
        sel_reg <= pick;
      end
    end
  end

  // frame output registers, held stable while offered
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      valid_reg <= 1'b0;
      pgn_reg <= 18'h00000;
      prio_reg <= 3'h0;
      data_reg <= {8{FILL_BYTE}};
    end else if (state_reg == JARP_LOAD) begin
      valid_reg <= 1'b1;
      pgn_reg <= pgn_next;
      prio_reg <= prio_next;
      data_reg <= data_next;
    end else if (frame_done) begin
      valid_reg <= 1'b0;
    end
  end

  assign FRAME_VALID = valid_reg;
  assign FRAME_PGN = pgn_reg;
  assign FRAME_PRIO = prio_reg;
  assign FRAME_DATA = data_reg;

  // ----------------------------------------
  // registers and interrupt
  // ----------------------------------------
  wire logic sent_slope = frame_done & (pgn_reg == PGN_EXT_SLOPE);
  wire logic sent_rate = frame_done & (pgn_reg == PGN_ANG_RATE);
  wire logic sent_dir = frame_done & (pgn_reg == PGN_VEH_DIR);
  wire logic sent_dir_two = frame_done & (pgn_reg == PGN_VEH_DIR_TWO);
  wire logic clip_ev = (state_reg == JARP_LOAD) & (|clip);
  wire logic rd_status = REG_RD & (REG_ADDR == ADDR_STATUS);
  wire logic [31:0] rd_mux;

  assign ev = {clip_ev, sent_dir_two, sent_dir, sent_rate, sent_slope};
  // read decode
  assign rd_mux = (REG_ADDR == ADDR_CTRL) ? ctrl_reg :
                  (REG_ADDR == ADDR_STATUS) ? {{(32 - NUM_EV){1'b0}}, status_reg} :
                  (REG_ADDR == ADDR_MASK) ? {{(32 - NUM_EV){1'b0}}, mask_reg} :
                  (REG_ADDR == ADDR_SENT) ? {16'h0000, sent_reg} : 32'h00000000;

  // control, mask and sticky status; a new event wins over the read clear
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ctrl_reg <= 32'h00000000;
      mask_reg <= '0;
      status_reg <= '0;
      sent_reg <= 16'h0000;
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == ADDR_CTRL) begin
        ctrl_reg <= {30'h00000000, REG_WDATA[CTRL_RATE_EN], REG_WDATA[CTRL_SLOPE_EN]};
      end
      if (REG_WR && REG_ADDR == ADDR_MASK) begin
        mask_reg <= REG_WDATA[NUM_EV-1:0];
      end
      status_reg <= (rd_status ? '0 : status_reg) | ev;
      sent_reg <= sent_reg + {15'h0000, frame_done};
      rdata_reg <= REG_RD ? rd_mux : 32'h00000000;
      irq_reg <= |(((rd_status ? '0 : status_reg) | ev) & mask_reg);
    end
  end

  assign REG_RDATA = rdata_reg;
  assign IRQ = irq_reg;
endmodule : jarp_packer

// File: src/jarp_pkg.sv
package jarp_pkg;
  // ----------------------------------------
  // parameter groups and priorities
  // ----------------------------------------
  localparam logic [17:0] PGN_EXT_SLOPE = 18'h0f029;   // 61481
  localparam logic [17:0] PGN_ANG_RATE = 18'h0f02a;    // 61482
  localparam logic [17:0] PGN_VEH_DIR = 18'h0fee8;     // 65256
  localparam logic [17:0] PGN_VEH_DIR_TWO = 18'h0fd89; // 64905
  localparam logic [2:0] PRIO_PERIODIC = 3'h3;
  localparam logic [2:0] PRIO_REQUEST = 3'h6;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int PERIOD_MS = 10;
  localparam int PERIOD_CYCLES = CLK_HZ / 1000 * PERIOD_MS;

  // ----------------------------------------
  // field limits, raw counts
  // ----------------------------------------
  localparam logic [23:0] EXT_ANGLE_MAX = 24'hfaffff;  // 251.9999 deg
  localparam logic [15:0] WORD_FIELD_MAX = 16'hfaff;   // largest valid 16 bit value
  localparam logic [7:0] LATENCY_MAX = 8'hfa;          // 125 ms at 0.5 ms per bit
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [15:0] FILL_WORD = 16'hffff;

  // ----------------------------------------
  // status codes
  // ----------------------------------------
  localparam logic [1:0] COMP_ON = 2'h0;
  localparam logic [1:0] COMP_OFF = 2'h1;
  localparam logic [1:0] STAT_ERROR = 2'h2;
  localparam logic [1:0] STAT_NA = 2'h3;
  localparam logic [1:0] MERIT_OK = 2'h0;
  localparam logic [1:0] MERIT_DEGRADED = 2'h1;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_SENT = 4'h3;
  localparam int CTRL_SLOPE_EN = 0;
  localparam int CTRL_RATE_EN = 1;
  localparam int EV_SLOPE = 0;
  localparam int EV_RATE = 1;
  localparam int EV_DIR = 2;
  localparam int EV_DIR_TWO = 3;
  localparam int EV_CLAMP = 4;
  localparam int NUM_EV = 5;

  typedef enum logic [1:0] {
    JARP_IDLE = 2'b00,
    JARP_LOAD = 2'b01,
    JARP_SEND = 2'b11
  } jarp_state_type;
endpackage : jarp_pkg

// File: src/jarp_timer.sv
`timescale 1ns/1ps
// free running period timer, one cycle tick at wrap
module jarp_timer
  import jarp_pkg::*;
#(
  parameter int CYCLES = PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // tick
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic tick_reg;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  assign count_next = (count_reg == LAST) ? '0 : count_reg + 1'b1;
  assign tick = tick_reg;

  // count and tick
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= (count_reg == LAST);
    end
  end
endmodule : jarp_timer

// File: verification/jarp_net_model.sv
`timescale 1ns/1ps
// receiving node: takes a frame at once, or after three cycles when slow
module jarp_net_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // frame handshake
  input wire logic frame_valid,
  input wire logic slow,
  output logic frame_ready
);
  logic [1:0] wait_reg;
  // count cycles a frame has been offered
  always_ff @(posedge clk) begin
    if (!reset_n || !frame_valid) wait_reg <= 2'h0;
    else wait_reg <= wait_reg + 2'h1;
  end
  // ready only after the wait when slow
  assign frame_ready = reset_n && (!slow || wait_reg == 2'h3);
endmodule : jarp_net_model

// File: verification/jarp_packer_bench.sv
`timescale 1ns/1ps
module jarp_packer_bench
  import jarp_pkg::*;
;
  localparam int PER = 50;
  localparam int LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic reset_n, reg_wr, reg_rd, irq, req_dir, req_dir_two, frame_valid, frame_ready, slow, rd_seen;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic signed [25:0] p_ext, r_ext;
  logic signed [17:0] p_rate, r_rate, y_rate, p_dir, r_dir;
  logic [8:0] a_lat, r_lat;
  logic [1:0] st [7];
  logic [17:0] frame_pgn;
  logic [2:0] frame_prio;
  logic [63:0] frame_data;
  logic [84:0] fq[$];
  logic [84:0] f_exp;
  logic [31:0] rq[$];
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  jarp_packer #(.PERIOD(PER)) i_jarp_packer (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq), .PITCH_EXT(p_ext), .ROLL_EXT(r_ext), .PITCH_RATE(p_rate),
    .ROLL_RATE(r_rate), .YAW_RATE(y_rate), .PITCH_DIR(p_dir), .ROLL_DIR(r_dir), .ANGLE_LATENCY(a_lat),
    .RATE_LATENCY(r_lat), .PITCH_COMP(st[0]), .PITCH_MERIT(st[1]), .ROLL_COMP(st[2]), .ROLL_MERIT(st[3]),
    .PITCH_RATE_MERIT(st[4]), .ROLL_RATE_MERIT(st[5]), .YAW_RATE_MERIT(st[6]), .REQ_DIR(req_dir),
    .REQ_DIR_TWO(req_dir_two), .FRAME_VALID(frame_valid), .FRAME_READY(frame_ready), .FRAME_PGN(frame_pgn),
    .FRAME_PRIO(frame_prio), .FRAME_DATA(frame_data));
  jarp_net_model i_jarp_net_model (.clk(sys_clk), .reset_n(reset_n), .frame_valid(frame_valid), .slow(slow),
    .frame_ready(frame_ready));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // saturate a biased count into [0, mx]
  function automatic logic [23:0] fit(input longint v, input longint mx);
    return (v < 0) ? 24'h0 : ((v > mx) ? 24'(mx) : 24'(v));
  endfunction : fit
  // below range, above range, or random in range
  function automatic longint pick(input int i, input longint r, input longint lo, input longint hi);
    return (i == 4) ? lo : ((i == 5) ? hi : r - 16000);
  endfunction : pick
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  // new measurements, every status code over the runs
  task set_in(input int i);
    seed = lfsr(seed);
    p_ext <= 26'(pick(i, seed[21:0], -8192001, 33554431));
    r_ext <= 26'(pick(i, seed[31:10], -8192001, 33554431));
    p_rate <= 18'(pick(i, seed[14:0], -32001, 131071));
    r_rate <= 18'(pick(i, seed[24:10], -32001, 131071));
    y_rate <= 18'(pick(i, seed[31:17], -32001, 131071));
    p_dir <= 18'(pick(i, seed[19:5], -25601, 131071));
    r_dir <= 18'(pick(i, seed[29:15], -25601, 131071));
    a_lat <= (i == 5) ? 9'h0fb : {2'h0, seed[6:0]};
    r_lat <= (i == 5) ? 9'h1ff : {2'h0, seed[13:7]};
    for (int j = 0; j < 7; j++) st[j] <= 2'(i + j);
  endtask : set_in
  // expected frame of kind k from the present inputs
  task note(input int k);
    logic [63:0] d;
    case (k)
      0: d = {8'(fit(a_lat, 250)), st[3], st[2], st[1], st[0], fit(r_ext + 8192000, 24'hfaffff),
        fit(p_ext + 8192000, 24'hfaffff)};
      1: d = {8'(fit(r_lat, 250)), 2'h3, st[6], st[5], st[4], 16'(fit(y_rate + 32000, 16'hfaff)),
        16'(fit(r_rate + 32000, 16'hfaff)), 16'(fit(p_rate + 32000, 16'hfaff))};
      2: d = {16'hffff, 16'(fit(p_dir + 25600, 16'hfaff)), 32'hffffffff};
      default: d = {48'hffffffffffff, 16'(fit(r_dir + 25600, 16'hfaff))};
    endcase
    fq.push_back({(k == 0) ? PGN_EXT_SLOPE : (k == 1) ? PGN_ANG_RATE : (k == 2) ? PGN_VEH_DIR : PGN_VEH_DIR_TWO,
      (k < 2) ? PRIO_PERIODIC : PRIO_REQUEST, d});
  endtask : note
  task drain();
    for (int n = 0; n < 300 && fq.size() != 0; n++) @(posedge sys_clk);
    check("frames left", 64'(fq.size()), 64'h0);
  endtask : drain
  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // clock
  initial forever #10 sys_clk = ~sys_clk;
  // read marker and hang limit
  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end
  // result watcher: read data and accepted frames against the oldest note
  initial forever @(negedge sys_clk) begin
    if (rd_seen) check("rdata", 64'(reg_rdata), 64'((rq.size() > 0) ? rq.pop_front() : 32'hffffffff));
    if (frame_valid && frame_ready) begin
      f_exp = (fq.size() > 0) ? fq.pop_front() : '1;
      check("pgn", 64'(frame_pgn), 64'(f_exp[84:67]));
      check("prio", 64'(frame_prio), 64'(f_exp[66:64]));
      check("data", frame_data, f_exp[63:0]);
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, req_dir, req_dir_two, slow} = '0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    seed = 32'h25;
    set_in(0);
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    wr(ADDR_MASK, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(4'h9, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    $display("test registers done");
    // requests, both at once, boundaries last
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      set_in(i);
      slow <= i[0];
      @(posedge sys_clk);
      note(2);
      note(3);
      req_dir <= 1'b1;
      req_dir_two <= 1'b1;
      @(posedge sys_clk);
      req_dir <= 1'b0;
      req_dir_two <= 1'b0;
      drain();
    end
    check("irq masked", 64'(irq), 64'h0);
    rd(ADDR_STATUS, 32'h1c);
    rd(ADDR_STATUS, 32'h0);
    $display("test requests done");
    // one period of both timed messages
    @(posedge sys_clk);
    set_in(1);
    @(posedge sys_clk);
    note(0);
    note(1);
    wr(ADDR_MASK, 32'h3);
    wr(ADDR_CTRL, 32'h3);
    drain();
    wr(ADDR_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    check("irq raised", 64'(irq), 64'h1);
    rd(ADDR_STATUS, 32'h3);
    rd(ADDR_SENT, 32'he);
    repeat (2) @(posedge sys_clk);
    check("irq cleared", 64'(irq), 64'h0);
    $display("test periodic done");
    give_verdict();
  end
endmodule : jarp_packer_bench

// File: verification/jarp_packer_props.sv
`timescale 1ns/1ps
module jarp_packer_checker
  import jarp_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYCLES
) (
  // clock and register port
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic IRQ,
  // frames
  input wire logic REQ_DIR,
  input wire logic FRAME_VALID,
  input wire logic FRAME_READY,
  input wire logic [17:0] FRAME_PGN,
  input wire logic [2:0] FRAME_PRIO,
  input wire logic [63:0] FRAME_DATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // frame kind and field range decode
  wire slope_f = FRAME_VALID && FRAME_PGN == PGN_EXT_SLOPE;
  wire rate_f = FRAME_VALID && FRAME_PGN == PGN_ANG_RATE;
  wire dir_f = FRAME_VALID && FRAME_PGN == PGN_VEH_DIR;
  wire dir2_f = FRAME_VALID && FRAME_PGN == PGN_VEH_DIR_TWO;
  wire ext_ok = FRAME_DATA[23:0] <= EXT_ANGLE_MAX && FRAME_DATA[47:24] <= EXT_ANGLE_MAX;
  wire lat_ok = FRAME_DATA[63:56] <= LATENCY_MAX;
  wire word_ok = FRAME_DATA[15:0] <= WORD_FIELD_MAX && FRAME_DATA[31:16] <= WORD_FIELD_MAX;
  // ----------------------------------------
  // frame checks
  // ----------------------------------------
  a_frame_hold: assert property (FRAME_VALID && !FRAME_READY |=> FRAME_VALID && $stable(FRAME_DATA))
    else $error("frame changed before accept");
  a_slope_prio: assert property (slope_f |-> FRAME_PRIO == PRIO_PERIODIC)
    else $error("slope priority wrong");
  a_slope_range: assert property (slope_f |-> ext_ok && lat_ok)
    else $error("slope field out of range");
  a_rate_fields: assert property (rate_f |-> word_ok && lat_ok && FRAME_DATA[55:54] == 2'h3)
    else $error("rate field wrong");
  a_req_prio: assert property (dir_f || dir2_f |-> FRAME_PRIO == PRIO_REQUEST)
    else $error("request priority wrong");
  a_dir_fill: assert property (dir_f |-> FRAME_DATA[31:0] == {2{FILL_WORD}} && FRAME_DATA[63:48] == FILL_WORD)
    else $error("direction fill wrong");
  a_dir_two_fill: assert property (dir2_f |-> FRAME_DATA[63:16] == {6{FILL_BYTE}})
    else $error("second direction fill wrong");
  a_req_answer: assert property ($rose(REQ_DIR) |-> ##[1:200] dir_f && FRAME_READY)
    else $error("request not answered");
  a_rdata_quiet: assert property (REG_RDATA != 32'h0 |-> $past(REG_RD))
    else $error("read data outside read cycle");
  // main scenarios
  c_slope: cover property (slope_f && FRAME_READY);
  c_dir: cover property (dir_f && FRAME_READY);
  c_stall: cover property (FRAME_VALID && !FRAME_READY);
  c_irq: cover property (IRQ);
endmodule : jarp_packer_checker

bind jarp_packer jarp_packer_checker #(.PERIOD(PERIOD)) i_jarp_packer_checker (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ), .REQ_DIR(REQ_DIR),
  .FRAME_VALID(FRAME_VALID), .FRAME_READY(FRAME_READY), .FRAME_PGN(FRAME_PGN), .FRAME_PRIO(FRAME_PRIO),
  .FRAME_DATA(FRAME_DATA));
